// >>> hw/gpcd_avg.sv
// Running average accumulator for one discharge cycle, latched at cycle end.
`timescale 1ns/1ps
`default_nettype none
module gpcd_avg (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Samples.
  input wire logic sample_i,
  input wire logic [31:0] value_i,
  input wire logic cycle_end_i,
  // Result.
  output logic [31:0] last_avg_o
);
  logic [47:0] sum_q;
  logic [15:0] n_q;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sum_q <= 48'h0;
      n_q <= 16'h0;
    end else if (cycle_end_i) begin
      sum_q <= 48'h0;
      n_q <= 16'h0;
    end else if (sample_i && n_q != 16'hFFFF) begin
      sum_q <= sum_q + {16'h0, value_i};
      n_q <= n_q + 16'h1;
    end
  end

  // A cycle without samples keeps the previous log instead of writing zero.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_avg_o <= 32'h0;
    end else if (cycle_end_i && n_q != 16'h0) begin
      last_avg_o <= 32'(sum_q / {32'h0, n_q});
    end
  end
endmodule
`default_nettype wire

// >>> hw/gpcd_pkg.sv
// Package with register map, field positions, reset values and timing counts for the gauge pin block.
package gpcd_pkg;
  localparam logic [3:0] ADDR_OPCFG = 4'h0;
  localparam logic [3:0] ADDR_OPCFG_EXT = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_INS_DELAY = 4'h3;
  localparam logic [3:0] ADDR_SLP_DELAY = 4'h4;
  localparam logic [3:0] ADDR_AVG_I_LAST = 4'h5;
  localparam logic [3:0] ADDR_AVG_P_LAST = 4'h6;
  localparam logic [3:0] ADDR_TEMP_LIMITS = 4'h7;
  localparam logic [3:0] ADDR_EXTRA_CHG = 4'h8;
  // Operation configuration field positions.
  localparam int B_TEMP_SRC = 0;
  localparam int B_PIN_FN = 1;
  localparam int B_GOOD_POL = 2;
  localparam int B_LOW_POL = 3;
  localparam int B_CAP_RELOAD = 4;
  localparam int B_SLEEP_EN = 5;
  localparam int B_PROFILE_SEL = 6;
  localparam int B_GND_SEL = 7;
  localparam int B_SENSE_LO = 8;
  localparam int B_SENSE_HI = 9;
  localparam int B_WAKE_LVL = 10;
  localparam int B_CODE_LO = 11;
  localparam int B_CODE_HI = 12;
  localparam int B_NO_STRETCH = 13;
  localparam int B_GOOD_OVR = 14;
  localparam int B_RESERVE = 15;
  localparam int B_SLP_WAKE_CHG = 6;
  localparam int B_RES_STEP = 7;
  localparam logic [15:0] OPCFG_RST = 16'h0979;
  localparam logic [7:0] OPCFG_EXT_RST = 8'h40;
  localparam logic [1:0] PFC_0 = 2'h0;
  localparam logic [1:0] PFC_1 = 2'h1;
  localparam logic [1:0] PFC_2 = 2'h2;
  // Timing.
  localparam int CLK_HZ = 10000000;
  localparam int POLL_PERIOD_MS = 1000;
  localparam int POLL_CYCLES = CLK_HZ / 1000 * POLL_PERIOD_MS;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int WAKE_CHG_S = 10;
  localparam logic [15:0] INS_DELAY_RST = 16'h0001;
  localparam logic [15:0] SLP_DELAY_RST = 16'h0002;
  localparam logic [15:0] TLIM_RST = 16'h2D00;
  localparam logic [7:0] HYS_RST = 8'h05;
  localparam logic [11:0] THERM_OPEN_MV = 12'h9C4;
  localparam logic [11:0] THERM_OPEN_BAND = 12'h064;
endpackage

// >>> hw/gpcd_tick.sv
// Free running tick generator: one pulse every PERIOD cycles.
`timescale 1ns/1ps
`default_nettype none
module gpcd_tick #(
  parameter int PERIOD = 10000
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Tick.
  output logic tick_o
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 32'h0;
    end else if (cnt_q == 32'(PERIOD - 1)) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign tick_o = (cnt_q == 32'(PERIOD - 1));
endmodule
`default_nettype wire

// >>> hw/gpcd_top.sv
// Gauge pin configuration, status pin drive, battery detection and last-run logging.
//
// Contract
// - Log average current and power per discharge cycle.
// - Delay detection and sleep after insertion.
// - No-stretch bit makes interface NACK during update.
// - Decode pin function code, default code one.
// - Current wake bits default to 0/0/1.
// - Ground select picks ADC reference pin.
// - Select bit chooses battery-low or battery-good.
// - Low polarity set means active-high low output.
// - Good polarity clear means active-low good output.
// - Override keeps good asserted on voltage hibernate.
// - Reload remaining from full on termination.
// - Temperature source set selects external thermistor.
// - Sleep enable permits sleep entry.
// - Add ten-second charge on current wake.
// - Code zero measures temperature always.
// - Code two skips charge temperature, keeps detected.
// - Code one drives high outside inhibit range.
// - Battery-low function follows charge-low flag.
// - Hold good disabled until voltage reading taken.
// - Poll detect pin each second, low present.
// - Thermistor near 2.5V means disconnected.
`timescale 1ns/1ps
`default_nettype none
module gpcd_top #(
  parameter int POLL_CYCLES = gpcd_pkg::POLL_CYCLES,
  parameter int MS_CYCLES = gpcd_pkg::MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Gauge measurements and events.
  input wire logic signed [15:0] current_ma_i,
  input wire logic [15:0] voltage_mv_i,
  input wire logic sample_i,
  input wire logic discharging_i,
  input wire logic charging_i,
  input wire logic signed [15:0] temperature_i,
  input wire logic [11:0] therm_mv_i,
  input wire logic charge_low_flag_i,
  input wire logic ocv_done_i,
  input wire logic hibernate_i,
  input wire logic hibernate_by_voltage_i,
  input wire logic charge_term_i,
  input wire logic [15:0] full_charge_capacity_i,
  input wire logic sleep_allowed_i,
  input wire logic sleep_current_wake_i,
  input wire logic signed [15:0] average_current_a_i,
  input wire logic flash_update_i,
  // Presence detect pin.
  input wire logic presence_detect_pin_i,
  output logic presence_detect_pin_o,
  output logic presence_detect_pin_oe_o,
  // Status pin and configuration outputs.
  output logic status_pin_o,
  output logic no_stretch_nack_o,
  output logic stretch_enable_o,
  output logic [1:0] pin_function_code_o,
  output logic [2:0] current_wake_cfg_o,
  output logic adc_ground_alt_o,
  output logic ext_thermistor_o,
  output logic temp_measure_en_o,
  output logic sleep_enter_o,
  output logic battery_detected_flag_o,
  output logic reload_strobe_o,
  output logic [15:0] remaining_capacity_o,
  output logic [31:0] extra_charge_o
);
  logic [15:0] opcfg_q;
  logic [7:0] opcfg_ext_q;
  logic [15:0] ins_delay_q;
  logic [15:0] slp_delay_q;
  logic [15:0] tlim_q;
  logic [7:0] hys_q;
  logic [31:0] rdata_d;
  logic poll_tick;
  logic ms_tick;
  logic cycle_end;
  logic dsg_q;
  logic [31:0] avg_i_last;
  logic [31:0] avg_p_last;
  logic [31:0] power_q;
  logic present_q;
  logic detected_q;
  logic [15:0] ins_ms_q;
  logic inhibit_q;
  logic good_q;
  logic [1:0] pin_function_code;
  logic therm_open;
  logic signed [7:0] t_lo;
  logic signed [7:0] t_hi;
  logic signed [8:0] hys;

  typedef enum logic [1:0] {
    GPCD_IDLE = 2'b00,
    GPCD_INS_WAIT = 2'b01,
    GPCD_DETECTED = 2'b10
  } gpcd_ins_e;
  gpcd_ins_e ins_q;

  function automatic logic [1:0] gpcd_code(input logic [15:0] cfg);
    gpcd_code = {cfg[gpcd_pkg::B_CODE_HI], cfg[gpcd_pkg::B_CODE_LO]};
  endfunction

  // Register writes.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      opcfg_q <= gpcd_pkg::OPCFG_RST;
      opcfg_ext_q <= gpcd_pkg::OPCFG_EXT_RST;
      ins_delay_q <= gpcd_pkg::INS_DELAY_RST;
      slp_delay_q <= gpcd_pkg::SLP_DELAY_RST;
      tlim_q <= gpcd_pkg::TLIM_RST;
      hys_q <= gpcd_pkg::HYS_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        gpcd_pkg::ADDR_OPCFG: begin
          opcfg_q <= reg_wdata_i[15:0];
        end
        gpcd_pkg::ADDR_OPCFG_EXT: begin
          opcfg_ext_q <= reg_wdata_i[7:0];
        end
        gpcd_pkg::ADDR_INS_DELAY: begin
          ins_delay_q <= reg_wdata_i[15:0];
        end
        gpcd_pkg::ADDR_SLP_DELAY: begin
          slp_delay_q <= reg_wdata_i[15:0];
        end
        gpcd_pkg::ADDR_TEMP_LIMITS: begin
          tlim_q <= reg_wdata_i[15:0];
          hys_q <= reg_wdata_i[23:16];
        end
        default: begin
        end
      endcase
    end
  end

  // Register reads; unmapped addresses read zero.
  always_comb begin
    rdata_d = 32'h0;
    case (reg_addr_i)
      gpcd_pkg::ADDR_OPCFG: rdata_d = {16'h0, opcfg_q};
      gpcd_pkg::ADDR_OPCFG_EXT: rdata_d = {24'h0, opcfg_ext_q};
      gpcd_pkg::ADDR_STATUS: rdata_d = {26'h0, ins_q, inhibit_q, good_q, detected_q, present_q};
      gpcd_pkg::ADDR_INS_DELAY: rdata_d = {16'h0, ins_delay_q};
      gpcd_pkg::ADDR_SLP_DELAY: rdata_d = {16'h0, slp_delay_q};
      gpcd_pkg::ADDR_AVG_I_LAST: rdata_d = avg_i_last;
      gpcd_pkg::ADDR_AVG_P_LAST: rdata_d = avg_p_last;
      gpcd_pkg::ADDR_TEMP_LIMITS: rdata_d = {8'h0, hys_q, tlim_q};
      gpcd_pkg::ADDR_EXTRA_CHG: rdata_d = extra_charge_o;
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  assign pin_function_code = gpcd_code(opcfg_q);
  assign pin_function_code_o = (pin_function_code == 2'h3) ? gpcd_pkg::PFC_1 : pin_function_code;
  assign current_wake_cfg_o = opcfg_q[gpcd_pkg::B_WAKE_LVL:gpcd_pkg::B_SENSE_LO];
  assign adc_ground_alt_o = opcfg_q[gpcd_pkg::B_GND_SEL];
  assign ext_thermistor_o = opcfg_q[gpcd_pkg::B_TEMP_SRC];
  assign no_stretch_nack_o = flash_update_i && opcfg_q[gpcd_pkg::B_NO_STRETCH];
  assign stretch_enable_o = flash_update_i && !opcfg_q[gpcd_pkg::B_NO_STRETCH];
  // Code two hands the thermistor to the charger while charging.
  assign temp_measure_en_o = !(pin_function_code_o == gpcd_pkg::PFC_2 && charging_i);

  // Discharge-cycle logging.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dsg_q <= 1'b0;
    end else begin
      dsg_q <= discharging_i;
    end
  end
  assign cycle_end = dsg_q && !discharging_i;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_q <= 32'h0;
    end else begin
      power_q <= 32'(unsigned'(current_ma_i < 0 ? -current_ma_i : current_ma_i)) * {16'h0, voltage_mv_i};
    end
  end

  gpcd_avg u_avg_i (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .sample_i(sample_i && discharging_i),
    .value_i({{16{current_ma_i[15]}}, current_ma_i}),
    .cycle_end_i(cycle_end),
    .last_avg_o(avg_i_last)
  );

  gpcd_avg u_avg_p (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .sample_i(sample_i && discharging_i),
    .value_i(power_q),
    .cycle_end_i(cycle_end),
    .last_avg_o(avg_p_last)
  );

  // Presence detection: pin stays released, sampled once per poll tick.
  gpcd_tick #(.PERIOD(POLL_CYCLES)) u_poll (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .tick_o(poll_tick)
  );

  gpcd_tick #(.PERIOD(MS_CYCLES)) u_ms (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .tick_o(ms_tick)
  );

  assign presence_detect_pin_o = 1'b0;
  assign presence_detect_pin_oe_o = 1'b0;
  assign therm_open = (therm_mv_i + gpcd_pkg::THERM_OPEN_BAND >= gpcd_pkg::THERM_OPEN_MV) &&
                      (therm_mv_i <= gpcd_pkg::THERM_OPEN_MV + gpcd_pkg::THERM_OPEN_BAND);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      present_q <= 1'b0;
    end else if (poll_tick) begin
      present_q <= !presence_detect_pin_i && !therm_open;
    end
  end

  // Insertion sequencing in milliseconds.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ins_q <= GPCD_IDLE;
      ins_ms_q <= 16'h0;
      detected_q <= 1'b0;
    end else begin
      case (ins_q)
        GPCD_IDLE: begin
          ins_ms_q <= 16'h0;
          detected_q <= 1'b0;
          if (present_q) begin
            ins_q <= GPCD_INS_WAIT;
          end
        end
        GPCD_INS_WAIT: begin
          if (!present_q) begin
            ins_q <= GPCD_IDLE;
          end else if (ms_tick) begin
            ins_ms_q <= ins_ms_q + 16'h1;
            if (ins_ms_q + 16'h1 >= ins_delay_q) begin
              ins_q <= GPCD_DETECTED;
              detected_q <= 1'b1;
            end
          end
        end
        GPCD_DETECTED: begin
          if (ms_tick && ins_ms_q != 16'hFFFF) begin
            ins_ms_q <= ins_ms_q + 16'h1;
          end
          // With code two a removal during charge leaves the flag standing.
          if (!present_q && !(pin_function_code_o == gpcd_pkg::PFC_2 && charging_i)) begin
            ins_q <= GPCD_IDLE;
          end
        end
        default: ins_q <= GPCD_IDLE;
      endcase
    end
  end
  assign battery_detected_flag_o = detected_q;
  assign sleep_enter_o = opcfg_q[gpcd_pkg::B_SLEEP_EN] && sleep_allowed_i && ins_q == GPCD_DETECTED &&
                         ins_ms_q >= slp_delay_q;

  // Battery good: disabled until the open-circuit reading is done.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      good_q <= 1'b0;
    end else if (ins_q != GPCD_DETECTED) begin
      good_q <= 1'b0;
    end else if (hibernate_i && !(opcfg_q[gpcd_pkg::B_GOOD_OVR] && hibernate_by_voltage_i)) begin
      good_q <= 1'b0;
    end else if (ocv_done_i) begin
      good_q <= 1'b1;
    end
  end

  // Charge inhibit with hysteresis, limits are signed bytes.
  assign t_lo = tlim_q[7:0];
  assign t_hi = tlim_q[15:8];
  assign hys = {1'b0, hys_q};
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inhibit_q <= 1'b0;
    end else if (pin_function_code_o != gpcd_pkg::PFC_1 || !charging_i) begin
      inhibit_q <= 1'b0;
    end else if (temperature_i < 16'(t_lo) || temperature_i > 16'(t_hi)) begin
      inhibit_q <= 1'b1;
    end else if (temperature_i >= 16'(t_lo) + 16'(hys) && temperature_i <= 16'(t_hi) - 16'(hys)) begin
      inhibit_q <= 1'b0;
    end
  end

  // Status pin: inhibit forces high; otherwise selected function with polarity.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_pin_o <= 1'b1;
    end else if (inhibit_q) begin
      status_pin_o <= 1'b1;
    end else if (opcfg_q[gpcd_pkg::B_PIN_FN]) begin
      status_pin_o <= opcfg_q[gpcd_pkg::B_GOOD_POL] ? good_q : !good_q;
    end else begin
      status_pin_o <= opcfg_q[gpcd_pkg::B_LOW_POL] ? charge_low_flag_i : !charge_low_flag_i;
    end
  end

  // Capacity reload on termination.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      remaining_capacity_o <= 16'h0;
      reload_strobe_o <= 1'b0;
    end else begin
      reload_strobe_o <= charge_term_i && opcfg_q[gpcd_pkg::B_CAP_RELOAD];
      if (charge_term_i && opcfg_q[gpcd_pkg::B_CAP_RELOAD]) begin
        remaining_capacity_o <= full_charge_capacity_i;
      end
    end
  end

  // Extra charge added when sleep is left on average current.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      extra_charge_o <= 32'h0;
    end else if (sleep_current_wake_i && opcfg_ext_q[gpcd_pkg::B_SLP_WAKE_CHG]) begin
      extra_charge_o <= 32'(signed'({{16{average_current_a_i[15]}}, average_current_a_i}) * gpcd_pkg::WAKE_CHG_S);
    end
  end

  // Checks.
  property p_nack;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (flash_update_i && opcfg_q[gpcd_pkg::B_NO_STRETCH]) |-> (no_stretch_nack_o && !stretch_enable_o);
  endproperty
  a_nack: assert property (p_nack) else $error("no-stretch not honoured");

  property p_good_wait;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (ins_q != GPCD_DETECTED) |=> !good_q;
  endproperty
  a_good_wait: assert property (p_good_wait) else $error("good asserted before detection");

  property p_low_follow;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (!inhibit_q && !opcfg_q[gpcd_pkg::B_PIN_FN] && opcfg_q[gpcd_pkg::B_LOW_POL]) |=> status_pin_o == $past(charge_low_flag_i);
  endproperty
  a_low_follow: assert property (p_low_follow) else $error("low pin not following flag");

  property p_inhibit_high;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      inhibit_q |=> status_pin_o;
  endproperty
  a_inhibit_high: assert property (p_inhibit_high) else $error("inhibit not high");

  property p_pin_released;
    @(posedge clk_sys_i) disable iff (!reset_n_i) !presence_detect_pin_oe_o;
  endproperty
  a_pin_released: assert property (p_pin_released) else $error("detect pin driven");

  property p_reload;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (charge_term_i && opcfg_q[gpcd_pkg::B_CAP_RELOAD]) |=> remaining_capacity_o == $past(full_charge_capacity_i);
  endproperty
  a_reload: assert property (p_reload) else $error("capacity not reloaded");

  property p_sleep;
    @(posedge clk_sys_i) disable iff (!reset_n_i) sleep_enter_o |-> opcfg_q[gpcd_pkg::B_SLEEP_EN];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without enable");

  property p_code2;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pin_function_code_o == gpcd_pkg::PFC_2 && charging_i) |-> !temp_measure_en_o;
  endproperty
  a_code2: assert property (p_code2) else $error("temp measured in code two charge");

  c_detect: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) $rose(detected_q));
  c_good: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) $rose(good_q));
  c_inhibit: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) $rose(inhibit_q));
endmodule
`default_nettype wire

// >>> tb/gpcd_partner.sv
// Far side model: pulled-up presence line with the battery contact, and a charger gated by the status pin.
`timescale 1ns/1ps
`default_nettype none
module gpcd_partner (
  // Clock.
  input wire logic clk_sys_i,
  // Battery contact and the gauge's view of the presence line.
  input wire logic battery_in_i,
  input wire logic pin_drive_i,
  input wire logic pin_oe_i,
  output logic pin_level_o,
  // Charger side.
  input wire logic status_pin_i,
  output logic charge_allowed_o
);
  // Released line floats to the pull-up unless a battery holds it low.
  assign pin_level_o = pin_oe_i ? pin_drive_i : !battery_in_i;
  // The charger stays off while the good line sits in its disabling high state.
  always_ff @(posedge clk_sys_i) begin
    charge_allowed_o <= battery_in_i && !status_pin_i;
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench for the gauge pin configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_i, reset_n_i, reg_wr_i, reg_rd_i, sample_i, discharging_i, charging_i;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, extra_charge_o;
  logic signed [15:0] current_ma_i, temperature_i, average_current_a_i;
  logic [15:0] voltage_mv_i, full_charge_capacity_i, remaining_capacity_o;
  logic [11:0] therm_mv_i;
  logic charge_low_flag_i, ocv_done_i, hibernate_i, hibernate_by_voltage_i, charge_term_i;
  logic sleep_allowed_i, sleep_current_wake_i, flash_update_i, battery_in, pin_level, charge_ok;
  logic pin_drv, pin_oe, status_pin_o, no_stretch_nack_o, stretch_enable_o, adc_ground_alt_o;
  logic ext_thermistor_o, temp_measure_en_o, sleep_enter_o, battery_detected_flag_o, reload_strobe_o;
  logic [1:0] pin_function_code_o;
  logic [2:0] current_wake_cfg_o, scnt;
  int err_count, tests_run;

  gpcd_top #(.POLL_CYCLES(20), .MS_CYCLES(4)) uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .current_ma_i(current_ma_i), .voltage_mv_i(voltage_mv_i), .sample_i(sample_i),
    .discharging_i(discharging_i), .charging_i(charging_i), .temperature_i(temperature_i),
    .therm_mv_i(therm_mv_i), .charge_low_flag_i(charge_low_flag_i), .ocv_done_i(ocv_done_i),
    .hibernate_i(hibernate_i), .hibernate_by_voltage_i(hibernate_by_voltage_i), .charge_term_i(charge_term_i),
    .full_charge_capacity_i(full_charge_capacity_i), .sleep_allowed_i(sleep_allowed_i),
    .sleep_current_wake_i(sleep_current_wake_i), .average_current_a_i(average_current_a_i),
    .flash_update_i(flash_update_i), .presence_detect_pin_i(pin_level), .presence_detect_pin_o(pin_drv),
    .presence_detect_pin_oe_o(pin_oe), .status_pin_o(status_pin_o), .no_stretch_nack_o(no_stretch_nack_o),
    .stretch_enable_o(stretch_enable_o), .pin_function_code_o(pin_function_code_o),
    .current_wake_cfg_o(current_wake_cfg_o), .adc_ground_alt_o(adc_ground_alt_o),
    .ext_thermistor_o(ext_thermistor_o), .temp_measure_en_o(temp_measure_en_o), .sleep_enter_o(sleep_enter_o),
    .battery_detected_flag_o(battery_detected_flag_o), .reload_strobe_o(reload_strobe_o),
    .remaining_capacity_o(remaining_capacity_o), .extra_charge_o(extra_charge_o));

  gpcd_partner partner (.clk_sys_i(clk_sys_i), .battery_in_i(battery_in), .pin_drive_i(pin_drv),
    .pin_oe_i(pin_oe), .pin_level_o(pin_level), .status_pin_i(status_pin_o), .charge_allowed_o(charge_ok));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Sample strobe every eight cycles; constant inputs keep the averages independent of the count.
  always @(posedge clk_sys_i) begin
    scnt <= scnt + 3'h1;
    sample_i <= (scnt == 3'h0);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic t_config;
    logic [31:0] d;
    rd(gpcd_pkg::ADDR_OPCFG, d);
    chk(d, 32'h0000_0979);
    rd(gpcd_pkg::ADDR_OPCFG_EXT, d);
    chk(d, 32'h0000_0040);
    rd(4'hF, d);
    chk(d, 32'h0000_0000);
    chk({29'h0, current_wake_cfg_o}, 32'h1);
    chk({31'h0, ext_thermistor_o}, 32'h1);
    for (int c = 0; c < 3; c++) begin
      wr(gpcd_pkg::ADDR_OPCFG, 32'h0979 & 32'hE7FF | (c << 11));
      chk({30'h0, pin_function_code_o}, c);
    end
    wr(gpcd_pkg::ADDR_OPCFG, 32'h09F8);
    chk({30'h0, adc_ground_alt_o, ext_thermistor_o}, 32'h2);
    flash_update_i <= 1'b1;
    wr(gpcd_pkg::ADDR_OPCFG, 32'h0979);
    chk({30'h0, no_stretch_nack_o, stretch_enable_o}, 32'h1);
    wr(gpcd_pkg::ADDR_OPCFG, 32'h2979);
    chk({30'h0, no_stretch_nack_o, stretch_enable_o}, 32'h2);
    flash_update_i <= 1'b0;
  endtask

  task automatic t_insert;
    logic [31:0] d;
    wr(gpcd_pkg::ADDR_OPCFG, 32'h097B);
    @(posedge clk_sys_i);
    battery_in <= 1'b1;
    for (int i = 0; i < 200 && battery_detected_flag_o !== 1'b1; i++) cyc(1);
    chk({30'h0, battery_detected_flag_o, pin_oe}, 32'h2);
    chk({30'h0, status_pin_o, charge_ok}, 32'h2);
    ocv_done_i <= 1'b1;
    cyc(3);
    chk({30'h0, status_pin_o, charge_ok}, 32'h1);
    // Override goes in first so that the hibernate entry never sees it clear.
    wr(gpcd_pkg::ADDR_OPCFG, 32'h497B);
    hibernate_i <= 1'b1;
    hibernate_by_voltage_i <= 1'b1;
    cyc(3);
    chk({31'h0, status_pin_o}, 32'h0);
    wr(gpcd_pkg::ADDR_OPCFG, 32'h097B);
    cyc(3);
    chk({31'h0, status_pin_o}, 32'h1);
    hibernate_i <= 1'b0;
    hibernate_by_voltage_i <= 1'b0;
    charging_i <= 1'b1;
    temperature_i <= 16'sd50;
    cyc(3);
    // Insertion state detected, inhibit, good, detected and present all set.
    rd(gpcd_pkg::ADDR_STATUS, d);
    chk(d, 32'h0000_002F);
    temperature_i <= 16'sd42;
    cyc(20);
    chk({31'h0, status_pin_o}, 32'h1);
    temperature_i <= 16'sd30;
    for (int i = 0; i < 60 && status_pin_o !== 1'b0; i++) cyc(1);
    chk({31'h0, status_pin_o}, 32'h0);
    charging_i <= 1'b0;
    wr(gpcd_pkg::ADDR_OPCFG, 32'h0979);
    charge_low_flag_i <= 1'b1;
    cyc(3);
    chk({31'h0, status_pin_o}, 32'h1);
    wr(gpcd_pkg::ADDR_OPCFG, 32'h0971);
    cyc(3);
    chk({31'h0, status_pin_o}, 32'h0);
    charge_low_flag_i <= 1'b0;
    wr(gpcd_pkg::ADDR_OPCFG, 32'h0979);
  endtask

  task automatic t_logs;
    logic [31:0] d;
    @(posedge clk_sys_i);
    discharging_i <= 1'b1;
    cyc(40);
    discharging_i <= 1'b0;
    cyc(5);
    rd(gpcd_pkg::ADDR_AVG_I_LAST, d);
    chk(d, 32'd100);
    rd(gpcd_pkg::ADDR_AVG_P_LAST, d);
    chk(d, 32'd400000);
    full_charge_capacity_i <= 16'h1234;
    charge_term_i <= 1'b1;
    @(posedge clk_sys_i);
    charge_term_i <= 1'b0;
    cyc(0);
    chk({31'h0, reload_strobe_o}, 32'h1);
    cyc(5);
    chk({16'h0, remaining_capacity_o}, 32'h1234);
    wr(gpcd_pkg::ADDR_OPCFG, 32'h0969);
    full_charge_capacity_i <= 16'h5678;
    charge_term_i <= 1'b1;
    @(posedge clk_sys_i);
    charge_term_i <= 1'b0;
    cyc(5);
    chk({16'h0, remaining_capacity_o}, 32'h1234);
    sleep_current_wake_i <= 1'b1;
    @(posedge clk_sys_i);
    sleep_current_wake_i <= 1'b0;
    cyc(5);
    chk(extra_charge_o, 32'd500);
    rd(gpcd_pkg::ADDR_EXTRA_CHG, d);
    chk(d, 32'd500);
    wr(gpcd_pkg::ADDR_OPCFG_EXT, 32'h0);
    // A new average proves that a disabled wake really adds nothing.
    average_current_a_i <= 16'sd70;
    sleep_current_wake_i <= 1'b1;
    @(posedge clk_sys_i);
    sleep_current_wake_i <= 1'b0;
    cyc(5);
    chk(extra_charge_o, 32'd500);
  endtask

  task automatic t_sleep_therm;
    sleep_allowed_i <= 1'b1;
    wr(gpcd_pkg::ADDR_OPCFG, 32'h0959);
    cyc(30);
    chk({31'h0, sleep_enter_o}, 32'h0);
    wr(gpcd_pkg::ADDR_OPCFG, 32'h0979);
    for (int i = 0; i < 100 && sleep_enter_o !== 1'b1; i++) cyc(1);
    chk({31'h0, sleep_enter_o}, 32'h1);
    sleep_allowed_i <= 1'b0;
    therm_mv_i <= 12'h9C4;
    for (int i = 0; i < 80 && battery_detected_flag_o !== 1'b0; i++) cyc(1);
    chk({31'h0, battery_detected_flag_o}, 32'h0);
    therm_mv_i <= 12'h3E8;
    wr(gpcd_pkg::ADDR_OPCFG, 32'h1179);
    charging_i <= 1'b1;
    for (int i = 0; i < 80 && battery_detected_flag_o !== 1'b1; i++) cyc(1);
    chk({30'h0, battery_detected_flag_o, temp_measure_en_o}, 32'h2);
    battery_in <= 1'b0;
    cyc(50);
    chk({31'h0, battery_detected_flag_o}, 32'h1);
    charging_i <= 1'b0;
    cyc(50);
    chk({30'h0, battery_detected_flag_o, temp_measure_en_o}, 32'h1);
  endtask

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #3000000;
    err_count++;
    conclude();
  end

  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, discharging_i, charging_i, charge_low_flag_i, ocv_done_i} = '0;
    {hibernate_i, hibernate_by_voltage_i, charge_term_i, sleep_allowed_i, sleep_current_wake_i} = '0;
    {flash_update_i, battery_in} = '0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    scnt = 3'h0;
    current_ma_i = 16'sd100;
    voltage_mv_i = 16'd4000;
    temperature_i = 16'sd25;
    therm_mv_i = 12'h3E8;
    full_charge_capacity_i = 16'h0;
    average_current_a_i = 16'sd50;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_config();
    t_insert();
    t_logs();
    t_sleep_therm();
    conclude();
  end
endmodule
`default_nettype wire
